// ==== logic/dpg_gpio.sv ====
// module: top of the dual-port gpio with pin wake-up
`timescale 1ns/10ps
module dpg_gpio (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        wdt_sleep_rst,
  input  wire logic [dpg_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic                        cpu_wr,
  input  wire dpg_pkg::dpg_op_type         cpu_op,
  input  wire logic [dpg_pkg::BIT_W-1:0]  cpu_bit,
  input  wire logic [dpg_pkg::PORT_W-1:0] cpu_wdata,
  input  wire logic                        cpu_rd,
  input  wire logic                        low_power,
  input  wire logic                        wake_ack,
  input  wire logic [dpg_pkg::PORT_W-1:0] pa_in,
  input  wire logic [dpg_pkg::PORT_W-1:0] pb_in,
  output logic      [dpg_pkg::PORT_W-1:0] cpu_rdata,
  output logic      [dpg_pkg::PORT_W-1:0] pa_out,
  output logic      [dpg_pkg::PORT_W-1:0] pa_oe,
  output logic      [dpg_pkg::PORT_W-1:0] pa_pullup,
  output logic      [dpg_pkg::PORT_W-1:0] pb_out,
  output logic      [dpg_pkg::PORT_W-1:0] pb_oe,
  output logic      [dpg_pkg::PORT_W-1:0] pb_pullup,
  output logic                             wake_req
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [dpg_pkg::PORT_W-1:0] a_data, a_dir, a_pu, a_wu, a_view, a_fall;
  logic [dpg_pkg::PORT_W-1:0] b_data, b_dir, b_pu, b_wu, b_view, b_fall;
  logic [dpg_pkg::PORT_W-1:0] sel_byte;
  logic [dpg_pkg::PORT_W-1:0] bit_mask;
  logic [dpg_pkg::PORT_W-1:0] wr_byte;
  logic [dpg_pkg::PORT_W-1:0] rdata_next;
  logic [dpg_pkg::PORT_W-1:0] pa_pu_next;
  logic [dpg_pkg::PORT_W-1:0] pb_pu_next;
  logic                        hit_any;
  logic                        keep;
  logic                        wake_next;
  logic                        wake_reg;

  // register selects, one location per port register
  wire a_sel_data = (cpu_addr == dpg_pkg::ADDR_PA_DATA); // [RULE1]
  wire a_sel_dir  = (cpu_addr == dpg_pkg::ADDR_PA_DIR);
  wire a_sel_pu   = (cpu_addr == dpg_pkg::ADDR_PA_PU);
  wire a_sel_wu   = (cpu_addr == dpg_pkg::ADDR_PA_WU);
  wire b_sel_data = (cpu_addr == dpg_pkg::ADDR_PB_DATA); // [RULE1]
  wire b_sel_dir  = (cpu_addr == dpg_pkg::ADDR_PB_DIR);
  wire b_sel_pu   = (cpu_addr == dpg_pkg::ADDR_PB_PU);
  wire b_sel_wu   = (cpu_addr == dpg_pkg::ADDR_PB_WU);

  // read mux: data locations show the port view, others their register;
  // every source is an argument so the caller's assign sees each change
  function automatic logic [dpg_pkg::PORT_W-1:0] read_mux(input logic [dpg_pkg::ADDR_W-1:0] a,
                                                           input logic [dpg_pkg::PORT_W-1:0] av,
                                                           input logic [dpg_pkg::PORT_W-1:0] ad,
                                                           input logic [dpg_pkg::PORT_W-1:0] ap,
                                                           input logic [dpg_pkg::PORT_W-1:0] aw,
                                                           input logic [dpg_pkg::PORT_W-1:0] bv,
                                                           input logic [dpg_pkg::PORT_W-1:0] bd,
                                                           input logic [dpg_pkg::PORT_W-1:0] bp,
                                                           input logic [dpg_pkg::PORT_W-1:0] bw);
    logic [dpg_pkg::PORT_W-1:0] r;
    r = dpg_pkg::ZERO;
    if (a == dpg_pkg::ADDR_PA_DATA) r = av;
    if (a == dpg_pkg::ADDR_PA_DIR)  r = ad;
    if (a == dpg_pkg::ADDR_PA_PU)   r = ap;
    if (a == dpg_pkg::ADDR_PA_WU)   r = aw;
    if (a == dpg_pkg::ADDR_PB_DATA) r = bv;
    if (a == dpg_pkg::ADDR_PB_DIR)  r = bd;
    if (a == dpg_pkg::ADDR_PB_PU)   r = bp;
    if (a == dpg_pkg::ADDR_PB_WU)   r = bw;
    return r;
  endfunction

  // pull-high only on input pins; no open-drain mode exists here
  function automatic logic [dpg_pkg::PORT_W-1:0] pu_gate(input logic [dpg_pkg::PORT_W-1:0] pu,
                                                          input logic [dpg_pkg::PORT_W-1:0] dir);
    return pu & dir;
  endfunction

  // ------------------------------------------------------------
  // read-modify-write
  // ------------------------------------------------------------
  // bit ops merge into the whole-port view, so input pins copy
  // their live level into the latch, as the real core does
  assign sel_byte = read_mux(cpu_addr, a_view, a_dir, a_pu, a_wu, b_view, b_dir, b_pu, b_wu); // [RULE12]
  assign bit_mask = dpg_pkg::PORT_W'(1) << cpu_bit;
  assign wr_byte  = (cpu_op == dpg_pkg::DPG_OP_SETBIT) ? (sel_byte | bit_mask) :
                    (cpu_op == dpg_pkg::DPG_OP_CLRBIT) ? (sel_byte & ~bit_mask) :
                    cpu_wdata; // [RULE12]
  assign keep     = wdt_sleep_rst; // [RULE13]

  dpg_port u_port_a (
    .clock     (clock),
    .rst       (rst),
    .keep      (keep),
    .sel_data  (a_sel_data),
    .sel_dir   (a_sel_dir),
    .sel_pu    (a_sel_pu),
    .sel_wu    (a_sel_wu),
    .wr_en     (cpu_wr),
    .wr_byte   (wr_byte),
    .pin_in    (pa_in),
    .low_power (low_power),
    .data_q    (a_data),
    .dir_q     (a_dir),
    .pu_q      (a_pu),
    .wu_q      (a_wu),
    .port_view (a_view),
    .fall_hit  (a_fall)
  );

  dpg_port u_port_b (
    .clock     (clock),
    .rst       (rst),
    .keep      (keep),
    .sel_data  (b_sel_data),
    .sel_dir   (b_sel_dir),
    .sel_pu    (b_sel_pu),
    .sel_wu    (b_sel_wu),
    .wr_en     (cpu_wr),
    .wr_byte   (wr_byte),
    .pin_in    (pb_in),
    .low_power (low_power),
    .data_q    (b_data),
    .dir_q     (b_dir),
    .pu_q      (b_pu),
    .wu_q      (b_wu),
    .port_view (b_view),
    .fall_hit  (b_fall)
  );

  // ------------------------------------------------------------
  // wake request and output staging
  // ------------------------------------------------------------
  // a new edge beats an ack in the same cycle, so no wake is lost
  assign hit_any    = |{a_fall, b_fall}; // [RULE6]
  assign wake_next  = hit_any | (wake_reg & ~wake_ack); // [RULE14]
  assign rdata_next = cpu_rd ? sel_byte : cpu_rdata; // [RULE2]
  assign pa_pu_next = pu_gate(a_pu, a_dir); // [RULE5]
  assign pb_pu_next = pu_gate(b_pu, b_dir); // [RULE5]

  // wake flag survives a low-power watchdog reset with the registers
  always_ff @(posedge clock) begin
    if (rst && !keep) begin
      wake_reg <= 1'b0;
    end else if (!rst) begin
      wake_reg <= wake_next;
    end
  end

  // pin drivers registered from the port registers, one cycle late
  always_ff @(posedge clock) begin
    if (rst && !keep) begin
      cpu_rdata <= dpg_pkg::ZERO;
      pa_out    <= dpg_pkg::RST_DATA;
      pa_oe     <= dpg_pkg::ZERO;
      pa_pullup <= dpg_pkg::ZERO;
      pb_out    <= dpg_pkg::RST_DATA;
      pb_oe     <= dpg_pkg::ZERO;
      pb_pullup <= dpg_pkg::ZERO;
    end else if (!rst) begin
      cpu_rdata <= rdata_next;
      pa_out    <= a_data;   // [RULE3]
      pa_oe     <= ~a_dir;   // [RULE9]
      pa_pullup <= pa_pu_next;
      pb_out    <= b_data;   // [RULE3]
      pb_oe     <= ~b_dir;   // [RULE9]
      pb_pullup <= pb_pu_next;
    end
  end

  assign wake_req = wake_reg;
endmodule

// ==== logic/dpg_pkg.sv ====
// package: register indices, reset values and widths for the dual gpio block
//
// What this block does
// RULE1: two 8-bit ports of pins, each pin usable as input or output, each port at a data-memory location.
// RULE2: a port read samples the pin level directly at the read strobe, with no input latch; the code does so for input pins only, output pins read the latch.
// RULE3: output data is held in a per-port latch that drives until that port's data location is written again.
// RULE4: each pin has a pull-high enable bit, 1 enables, all cleared to 0 by reset.
// RULE5: the pull-high acts only while the pin is a digital input, otherwise it stays off.
// RULE6: in sleep or idle a falling edge on any wake-enabled pin of either port wakes the device.
// RULE7: a wake enable counts only when the pin is an input and the core is in idle or sleep.
// RULE8: each pin has a wake enable bit, 1 enables, all cleared to 0 by reset.
// RULE9: each pin has a direction bit, 1 input, 0 cmos output from the data latch, changeable at any time.
// RULE10: reading a port returns the data latch for output pins, not the pin level.
// RULE11: reset sets all data latches and all direction bits to 1.
// RULE12: bit set and clear on a port read the whole port, change one bit and write the byte back.
// RULE13: a watchdog reset during idle or sleep leaves all port registers unchanged; other resets restore defaults.
// RULE14: the wake detector compares each qualifying pin with its last sample and holds a wake request until acknowledged.
package dpg_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BIT_W  = 3;

  // register locations in data memory, placed by the integrator
  localparam logic [ADDR_W-1:0] ADDR_PA_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_PA_DIR  = 8'h15;
  localparam logic [ADDR_W-1:0] ADDR_PA_PU   = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_PA_WU   = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_PB_DATA = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_PB_DIR  = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_PB_PU   = 8'h1a;
  localparam logic [ADDR_W-1:0] ADDR_PB_WU   = 8'h1b;

  // reset values
  localparam logic [PORT_W-1:0] RST_DATA = 8'hff;
  localparam logic [PORT_W-1:0] RST_DIR  = 8'hff;
  localparam logic [PORT_W-1:0] RST_PU   = 8'h00;
  localparam logic [PORT_W-1:0] RST_WU   = 8'h00;
  localparam logic [PORT_W-1:0] ZERO     = 8'h00;

  // direction encoding
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN  = 1'b1;

  // cpu access kinds
  typedef enum logic [1:0] {
    DPG_OP_WRITE,
    DPG_OP_SETBIT,
    DPG_OP_CLRBIT
  } dpg_op_type;
endpackage

// ==== logic/dpg_port.sv ====
// module: one 8-bit port with data, direction, pull-high and wake enable registers
`timescale 1ns/10ps
module dpg_port (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        keep,
  input  wire logic                        sel_data,
  input  wire logic                        sel_dir,
  input  wire logic                        sel_pu,
  input  wire logic                        sel_wu,
  input  wire logic                        wr_en,
  input  wire logic [dpg_pkg::PORT_W-1:0] wr_byte,
  input  wire logic [dpg_pkg::PORT_W-1:0] pin_in,
  input  wire logic                        low_power,
  output logic      [dpg_pkg::PORT_W-1:0] data_q,
  output logic      [dpg_pkg::PORT_W-1:0] dir_q,
  output logic      [dpg_pkg::PORT_W-1:0] pu_q,
  output logic      [dpg_pkg::PORT_W-1:0] wu_q,
  output logic      [dpg_pkg::PORT_W-1:0] port_view,
  output logic      [dpg_pkg::PORT_W-1:0] fall_hit
);
  logic [dpg_pkg::PORT_W-1:0] data_reg;
  logic [dpg_pkg::PORT_W-1:0] dir_reg;
  logic [dpg_pkg::PORT_W-1:0] pu_reg;
  logic [dpg_pkg::PORT_W-1:0] wu_reg;
  logic [dpg_pkg::PORT_W-1:0] prev_reg;
  logic [dpg_pkg::PORT_W-1:0] wake_qual;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // keep marks a watchdog reset in a low-power mode: contents hold
  always_ff @(posedge clock) begin
    if (rst && !keep) begin // [RULE13]
      data_reg <= dpg_pkg::RST_DATA; // [RULE11]
      dir_reg  <= dpg_pkg::RST_DIR;  // [RULE11]
      pu_reg   <= dpg_pkg::RST_PU;   // [RULE4]
      wu_reg   <= dpg_pkg::RST_WU;   // [RULE8]
    end else if (!rst && wr_en) begin
      if (sel_data) data_reg <= wr_byte; // [RULE3]
      if (sel_dir)  dir_reg  <= wr_byte; // [RULE9]
      if (sel_pu)   pu_reg   <= wr_byte; // [RULE4]
      if (sel_wu)   wu_reg   <= wr_byte; // [RULE8]
    end
  end

  // previous pin sample for the edge compare; a held keep reset keeps
  // tracking the pins so a low pin is not seen as a fresh edge; other resets load all ones
  always_ff @(posedge clock) begin
    if (rst && !keep) begin
      prev_reg <= dpg_pkg::RST_DATA;
    end else begin
      prev_reg <= pin_in; // [RULE14]
    end
  end

  // ------------------------------------------------------------
  // read view and wake qualification
  // ------------------------------------------------------------
  // output pins read back the latch, input pins the live level
  assign port_view = (dir_reg & pin_in) | (~dir_reg & data_reg); // [RULE2] [RULE10]
  assign wake_qual = low_power ? (wu_reg & dir_reg) : dpg_pkg::ZERO; // [RULE7]
  assign fall_hit  = wake_qual & prev_reg & ~pin_in; // [RULE6] [RULE14]
  assign data_q    = data_reg;
  assign dir_q     = dir_reg;
  assign pu_q      = pu_reg;
  assign wu_q      = wu_reg;
endmodule

// ==== tb/dpg_gpio_asserts.sv ====
// checker: assertions on the dual gpio top-level ports
`timescale 1ns/10ps
module dpg_gpio_asserts (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                wdt_sleep_rst,
  input wire logic [7:0]          cpu_addr,
  input wire logic                cpu_wr,
  input wire dpg_pkg::dpg_op_type cpu_op,
  input wire logic [7:0]          cpu_wdata,
  input wire logic                cpu_rd,
  input wire logic                low_power,
  input wire logic                wake_ack,
  input wire logic [7:0]          cpu_rdata,
  input wire logic [7:0]          pa_out,
  input wire logic [7:0]          pa_oe,
  input wire logic [7:0]          pa_pullup,
  input wire logic [7:0]          pb_out,
  input wire logic [7:0]          pb_oe,
  input wire logic                wake_req
);
  // ----------------------------------------
  // port relations, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_dir_to_oe: assert property (
    cpu_wr && cpu_op == dpg_pkg::DPG_OP_WRITE && cpu_addr == dpg_pkg::ADDR_PA_DIR |-> ##2 pa_oe == ~$past(cpu_wdata, 2))
    else $error("oe does not follow direction write");
  // a data write reaches the pin drive one edge after it is taken
  chk_out_hold: assert property (
    !(cpu_wr && cpu_addr == dpg_pkg::ADDR_PA_DATA) |-> ##2 $stable(pa_out))
    else $error("pin drive moved without write");
  chk_pu_follow: assert property (
    cpu_wr && cpu_op == dpg_pkg::DPG_OP_WRITE && cpu_addr == dpg_pkg::ADDR_PA_PU
    |-> ##2 pa_pullup == ($past(cpu_wdata, 2) & ~pa_oe)) else $error("pull-high not gated by direction");
  // reset checks must not be masked by reset itself
  chk_reset_dflt: assert property (disable iff (1'b0)
    rst && !wdt_sleep_rst ##1 rst && !wdt_sleep_rst |=> pa_oe == 8'h00 && pb_oe == 8'h00 && pa_out == 8'hff
    && pb_out == 8'hff && pa_pullup == 8'h00 && !wake_req && cpu_rdata == 8'h00) else $error("reset values wrong");
  chk_wdt_keep: assert property (disable iff (1'b0)
    rst && wdt_sleep_rst ##1 rst && wdt_sleep_rst |=> $stable(pa_out) && $stable(pb_oe) && $stable(pa_pullup))
    else $error("sleep watchdog reset changed state");
  chk_unmapped_rd: assert property (
    cpu_rd && (cpu_addr < dpg_pkg::ADDR_PA_DATA || cpu_addr > dpg_pkg::ADDR_PB_WU) |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_wake_hold: assert property (
    wake_req && !wake_ack |=> wake_req) else $error("wake request dropped early");
  chk_wake_ack: assert property (
    wake_req && wake_ack && !low_power |=> !wake_req) else $error("wake request not cleared");
  chk_wake_awake: assert property (
    !low_power && !wake_req |=> !wake_req) else $error("wake raised while awake");
endmodule
bind dpg_gpio dpg_gpio_asserts chk (.clock(clock), .rst(rst), .wdt_sleep_rst(wdt_sleep_rst),
  .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_op(cpu_op), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
  .low_power(low_power), .wake_ack(wake_ack), .cpu_rdata(cpu_rdata), .pa_out(pa_out), .pa_oe(pa_oe),
  .pa_pullup(pa_pullup), .pb_out(pb_out), .pb_oe(pb_oe), .wake_req(wake_req));

// ==== tb/dpg_pins_model.sv ====
// partner: board switches and wiring on one port's pins
`timescale 1ns/10ps
module dpg_pins_model (
  input  wire logic       clock,
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pu_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin
);
  logic [7:0] last_reg = 8'h00;
  // a floating line without pull-high shows the inverse of its last level, so stale data never passes
  assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu_en | ~last_reg));
  always_ff @(posedge clock) begin
    last_reg <= pin;
  end
endmodule

// ==== tb/dpg_gpio_tb_top.sv ====
// testbench: register, pin and wake scenarios for the dual gpio block
`timescale 1ns/10ps
module dpg_gpio_tb_top;
  localparam logic [7:0] PA = dpg_pkg::ADDR_PA_DATA;
  localparam logic [7:0] PB = dpg_pkg::ADDR_PB_DATA;
  logic                clock, rst, wdt_sleep_rst, cpu_wr, cpu_rd, low_power, wake_ack, wake_req, rd_d;
  logic [7:0]          cpu_addr, cpu_wdata, cpu_rdata, pa_in, pb_in, pa_out, pa_oe, pa_pullup;
  logic [7:0]          pb_out, pb_oe, pb_pullup, ea, eb, d, fa, fb;
  logic [2:0]          cpu_bit;
  logic [31:0]         seed;
  dpg_pkg::dpg_op_type cpu_op;
  logic [7:0]          exp_q[$];
  int                  error_cnt, checks, i;
  // ----------------------------------------
  // design, pin models and helpers
  // ----------------------------------------
  dpg_gpio uut (.clock(clock), .rst(rst), .wdt_sleep_rst(wdt_sleep_rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_op(cpu_op), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .low_power(low_power),
    .wake_ack(wake_ack), .pa_in(pa_in), .pb_in(pb_in), .cpu_rdata(cpu_rdata), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pullup(pa_pullup), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup), .wake_req(wake_req));
  // fa and fb mark pins left floating by the board, so pull-highs can be seen
  dpg_pins_model pam (.clock(clock), .out(pa_out), .oe(pa_oe), .pu_en(pa_pullup), .ext_en(~fa), .ext_val(ea),
    .pin(pa_in));
  dpg_pins_model pbm (.clock(clock), .out(pb_out), .oe(pb_oe), .pu_en(pb_pullup), .ext_en(~fb), .ext_val(eb),
    .pin(pb_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic fail(string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic ck(logic [7:0] g, logic [7:0] e, string m);
    checks++;
    if (g !== e) fail(m);
  endtask
  task automatic st(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one write: held up to the taking edge, dropped right at it
  task automatic w(logic [7:0] a, logic [7:0] v, dpg_pkg::dpg_op_type o = dpg_pkg::DPG_OP_WRITE, logic [2:0] b = 3'h0);
    @(posedge clock);
    cpu_addr  <= a;
    cpu_wdata <= v;
    cpu_op    <= o;
    cpu_bit   <= b;
    cpu_wr    <= 1'b1;
    @(posedge clock);
    cpu_wr <= 1'b0;
  endtask
  task automatic r(logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    cpu_rd <= 1'b0;
  endtask
  // read answers land one edge after the strobe; oldest note first
  always @(posedge clock) rd_d <= cpu_rd;
  always @(negedge clock) begin
    if (rd_d) begin
      checks++;
      if (exp_q.size() == 0 || cpu_rdata !== exp_q.pop_front()) fail("read data mismatch");
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, wdt_sleep_rst, cpu_wr, cpu_rd, low_power, wake_ack} = 6'b100000;
    {cpu_addr, cpu_wdata, cpu_bit, error_cnt, checks, fa, fb} = '0;
    cpu_op = dpg_pkg::DPG_OP_WRITE;
    seed = 32'hda86365b;
    ea = rnd();
    eb = 8'hff;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) r(PA + 8'(i), i % 4 == 1 ? 8'hff : i == 0 ? ea : i == 4 ? eb : 8'h00);
    r(8'h20, 8'h00);
    d = rnd();
    w(PA, d);
    r(PA, ea);
    w(PA + 8'h1, 8'h00);
    st(2);
    ck(pa_oe, 8'hff, "oe");
    ck(pa_out, d, "latched drive");
    ea = ~d;
    r(PA, d);
    w(PB + 8'h1, 8'h00);
    st(2);
    ck(pb_out, 8'hff, "default drive");
    // upper half inputs: the bit set folds live pins into the latch
    w(PA + 8'h1, 8'hf0);
    w(PA + 8'h2, 8'hff);
    w(PA, 8'h00, dpg_pkg::DPG_OP_SETBIT, 3'h0);
    st(2);
    ck(pa_pullup, 8'hf0, "pull-high gating");
    w(PA + 8'h1, 8'h00, dpg_pkg::DPG_OP_CLRBIT, 3'h7);
    r(PA + 8'h1, 8'h70);
    w(PA + 8'h1, 8'h00);
    st(2);
    ck(pa_out, (ea & 8'hf0) | (d & 8'h0f) | 8'h01, "bit set");
    w(PB + 8'h1, 8'hff);
    w(PB + 8'h3, 8'h01);
    @(posedge clock);
    eb <= 8'hfe;
    st(4);
    ck({7'h00, wake_req}, 8'h00, "wake while awake");
    @(posedge clock);
    eb <= 8'hfd;
    low_power <= 1'b1;
    st(4);
    ck({7'h00, wake_req}, 8'h00, "wake from disabled pin");
    @(posedge clock);
    eb <= 8'hfe;
    for (i = 0; i < 20 && wake_req !== 1'b1; i++) @(posedge clock);
    if (i == 20) fail("wake timeout");
    if (i == 20) summarize();
    st(3);
    ck({7'h00, wake_req}, 8'h01, "wake held");
    @(posedge clock);
    wake_ack <= 1'b1;
    low_power <= 1'b0;
    @(posedge clock);
    wake_ack <= 1'b0;
    #1;
    ck({7'h00, wake_req}, 8'h00, "wake cleared");
    @(posedge clock);
    {rst, wdt_sleep_rst} <= 2'b11;
    repeat (3) @(posedge clock);
    {rst, wdt_sleep_rst} <= 2'b00;
    r(PB + 8'h3, 8'h01);
    r(PA + 8'h1, 8'h00);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    r(PA + 8'h1, 8'hff);
    r(PB + 8'h3, 8'h00);
    // lower pins of port b float: only the pull-high can hold them at 1, left alone they toggle each cycle
    fb <= 8'h0f;
    w(PB + 8'h2, 8'h0f);
    r(PB, 8'hff);
    st(3);
    ck(pb_pullup, 8'h0f, "pull-high on input pins");
    summarize();
  end
endmodule
